// ===== shared/bridge_dsp_pkg.sv
/*
  Package for the bridge sensor correction core: timing, store layout,
  configuration encodings and the carrier structs.
  Assumes a 50 MHz core clock.
*/
package bridge_dsp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          CONV_TIME_US    = 1000;
  localparam int          CONV_CYCLES     = CLK_HZ / 1_000_000 * CONV_TIME_US;
  localparam int          PROG_TIME_MS    = 6;
  localparam int          PROG_CYCLES     = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int          AZ_CYCLES       = 16;

  // ----------------------------------------------------------------
  // Data widths and store layout
  // ----------------------------------------------------------------
  localparam int          ADC_W           = 14;
  localparam int          TEMP_W          = 12;
  localparam int          TEMP_OUT_W      = 8;
  localparam int          NV_BYTES        = 16;
  localparam int          NV_AW           = 4;
  localparam logic [3:0]  NV_GAIN_B_LO    = 4'h0;
  localparam logic [3:0]  NV_GAIN_B_HI    = 4'h1;
  localparam logic [3:0]  NV_OFS_B_LO     = 4'h2;
  localparam logic [3:0]  NV_OFS_B_HI     = 4'h3;
  localparam logic [3:0]  NV_TCO          = 4'h4;
  localparam logic [3:0]  NV_TCG          = 4'h5;
  localparam logic [3:0]  NV_SOT          = 4'h6;
  localparam logic [3:0]  NV_GAIN_T       = 4'h7;
  localparam logic [3:0]  NV_OFS_T        = 4'h8;
  localparam logic [3:0]  NV_TSETL_LO     = 4'h9;
  localparam logic [3:0]  NV_TSETL_HI     = 4'hA;
  localparam logic [3:0]  NV_CFG0         = 4'hB;
  localparam logic [3:0]  NV_CFG1         = 4'hC;
  localparam logic [3:0]  NV_CUST0        = 4'hD;
  localparam logic [3:0]  NV_CUST1        = 4'hE;
  localparam logic [3:0]  NV_CUST2        = 4'hF;

  // CFG0 fields, and the CFG1 second-order select (CFG_SOT_LSB)
  localparam int          CFG_GAIN_LSB    = 0;
  localparam int          CFG_REV_BIT     = 2;
  localparam int          CFG_ZERO_LSB    = 3;
  localparam int          CFG_RATE_LSB    = 5;
  localparam int          CFG_SOT_LSB     = 0;

  // Gain 1.25 in Q2.12 is 5120
  localparam logic [15:0] K_1P25          = 16'h1400;
  localparam logic [13:0] ADC_MAX         = 14'h3FFF;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SOT_BRIDGE = 2'h0,
    SOT_TCO    = 2'h1,
    SOT_TCG    = 2'h2
  } sot_sel_t;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_READ  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_RAW   = 2'h3
  } cmd_t;

  typedef struct packed {
    cmd_t        cmd;
    logic [3:0]  addr;
    logic [7:0]  data;
  } host_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } host_rsp_t;

  typedef struct packed {
    logic [13:0] bridge;
    logic [7:0]  temp;
    logic        valid;
  } result_t;

endpackage

// ===== src/bridge_sensor_correction_dsp.sv
/*
  Digital core of a resistive-bridge conditioner: conversion sequencing,
  bridge switch control, store, correction datapath, command port.
  Assumes the converter returns one result per conversion phase (auto-zero, temperature, bridge) with
  i_adc_done, and that the one-wire bit layer is outside this block.
*/
`timescale 1ns/10ps
`default_nettype none

module bridge_sensor_correction_dsp
  import bridge_dsp_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int PROG_CYC = PROG_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire host_req_t   i_req,
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  output host_rsp_t        o_rsp,
  input  wire logic [13:0] i_adc_data,
  input  wire logic        i_adc_done,
  output logic             o_conv_start,
  output logic             o_conv_temp,
  output logic             o_conv_az,
  output logic             o_bridge_sw_on,
  output logic [1:0]       o_pga_gain,
  output logic             o_input_swap,
  output logic [1:0]       o_adc_zero,
  output result_t          o_result
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_AZ    = 6'b000001,
    S_TEMP  = 6'b000010,
    S_BR    = 6'b000100,
    S_CALC  = 6'b001000,
    S_IDLE  = 6'b010000,
    S_PROG  = 6'b100000
  } st_t;

  typedef struct packed {
    st_t         st;
    logic        busy;
    logic [2:0]  step;
    logic [31:0] cnt;
    logic [13:0] az;
    logic [13:0] t_raw;
    logic [13:0] b_raw;
    logic [13:0] br;
    logic [7:0]  temp;
    logic        valid;
    logic [127:0] nv;
    logic [3:0]  rd_ptr;
    logic        rsp_v;
    logic [7:0]  rsp_d;
    logic [3:0]  pw_addr;
    logic [7:0]  pw_data;
    logic signed [31:0] zb;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ----------------------------------------------------------------
  // Coefficient views
  // ----------------------------------------------------------------
  function automatic logic [7:0] nvb(input logic [127:0] nv,
                                     input logic [3:0] a);
    nvb = nv[{a, 3'b000} +: 8];
  endfunction

  logic [15:0]        gain_b;
  logic [15:0]        ofs_b;
  logic signed [7:0]  tco;
  logic signed [7:0]  tcg;
  logic signed [7:0]  second_order_coefficient;
  logic [7:0]         gain_t;
  logic signed [7:0]  ofs_t;
  logic [11:0]        low_cal_temp_reference;
  logic [7:0]         cfg0;
  logic [7:0]         cfg1;
  logic [7:0]         tsetl_hi;
  sot_sel_t           sot_sel;
  logic [1:0]         rate;
  logic signed [12:0] dt;
  logic signed [31:0] gfac;
  logic signed [31:0] ofac;
  logic signed [31:0] sdt;
  logic signed [47:0] zprod;
  logic signed [47:0] brprod;
  logic signed [31:0] brq;
  logic [31:0]        idle_cyc;
  logic [15:0]        tprod;

  // Coefficients come straight from the store image
  assign gain_b  = {nvb(s_r.nv, NV_GAIN_B_HI), nvb(s_r.nv, NV_GAIN_B_LO)};
  assign ofs_b   = {nvb(s_r.nv, NV_OFS_B_HI), nvb(s_r.nv, NV_OFS_B_LO)};
  assign tco     = nvb(s_r.nv, NV_TCO);
  assign tcg     = nvb(s_r.nv, NV_TCG);
  assign second_order_coefficient     = nvb(s_r.nv, NV_SOT);
  assign gain_t  = nvb(s_r.nv, NV_GAIN_T);
  assign ofs_t   = nvb(s_r.nv, NV_OFS_T);
  assign tsetl_hi = nvb(s_r.nv, NV_TSETL_HI);
  assign low_cal_temp_reference  = {tsetl_hi[3:0], nvb(s_r.nv, NV_TSETL_LO)};
  assign cfg0    = nvb(s_r.nv, NV_CFG0);
  assign cfg1    = nvb(s_r.nv, NV_CFG1);
  assign sot_sel = sot_sel_t'(cfg1[CFG_SOT_LSB +: 2]);
  assign rate    = cfg0[CFG_RATE_LSB +: 2];

  // Upper twelve bits only dT
  assign dt   = $signed({1'b0, s_r.t_raw[13:2]}) - $signed({1'b0, low_cal_temp_reference});
  assign sdt  = 32'(second_order_coefficient * dt);
  // Gain factor in Q12; second order on gain drift
  assign gfac = (sot_sel == SOT_TCG)
              ? 32'sd4096 + 32'((dt * (sdt + 32'(tcg))) >>> 6)
              : 32'sd4096 + 32'((dt * tcg) >>> 6);
  // Offset term; second order on offset drift
  assign ofac = $signed({18'h0, s_r.b_raw}) - $signed({16'h0, ofs_b})
              + ((sot_sel == SOT_TCO) ? 32'((dt * (sdt + 32'(tco))) >>> 4)
                                      : 32'((dt * tco) >>> 4));
  assign zprod = 48'(($signed({16'h0, gain_b}) * gfac) >>> 12) * ofac;
  // Two-step bridge form; 1.25 scaling only when SOT_BRIDGE is selected
  assign brprod = (sot_sel == SOT_BRIDGE)
                ? 48'(s_r.zb) * 48'($signed({16'h0, K_1P25})
                  + 32'((second_order_coefficient * s_r.zb) >>> 14))
                : 48'(s_r.zb) <<< 12;
  // Factor is Q12 and the intermediate is whole counts: drop 12 bits
  assign brq = 32'(brprod >>> 12);
  // Linear temperature upper eight bits out
  // Offset is widened on its own so a negative value keeps its sign
  assign tprod = 16'(gain_t * (16'($signed({1'b0, s_r.t_raw[13:2]}))
                               + 16'(ofs_t)));
  // Idle gap per rate: 0,4,19,99 conversions
  always_comb begin
    case (rate)
      2'h0:    idle_cyc = 32'h0000_0000;
      2'h1:    idle_cyc = 32'(4 * CONV_CYC);
      2'h2:    idle_cyc = 32'(19 * CONV_CYC);
      default: idle_cyc = 32'(99 * CONV_CYC);
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.rsp_v = 1'b0;
    case (s_r.st)
      S_AZ: begin
        if (i_adc_done) begin
          s_nxt.az = i_adc_data;
          s_nxt.st = S_TEMP;
        end
      end
      S_TEMP: begin
        if (i_adc_done) begin
          s_nxt.t_raw = i_adc_data;
          s_nxt.st    = S_BR;
        end
      end
      S_BR: begin
        if (i_adc_done) begin
          // Auto-zero removed from the 14-bit reading
          s_nxt.b_raw = (i_adc_data > s_r.az) ? 14'(i_adc_data - s_r.az)
                                              : 14'h0000;
          s_nxt.st    = S_CALC;
          s_nxt.step  = 3'h0;
        end
      end
      S_CALC: begin
        s_nxt.step = 3'(s_r.step + 3'h1);
        if (s_r.step == 3'h0) begin
          s_nxt.zb = 32'(zprod >>> 12);
        end else begin
          // Saturate instead of wrapping
          if (brq < 0) begin
            s_nxt.br = 14'h0000;
          end else if (brq > $signed({18'h0, ADC_MAX})) begin
            s_nxt.br = ADC_MAX;
          end else begin
            s_nxt.br = brq[13:0];
          end
          s_nxt.temp  = tprod[15:8];
          s_nxt.valid = 1'b1;
          s_nxt.cnt   = 32'h0000_0000;
          s_nxt.st    = S_IDLE;
        end
      end
      S_IDLE: begin
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        if (s_r.busy) begin
          s_nxt.st  = S_PROG;
          s_nxt.cnt = 32'h0000_0000;
        end else if (s_r.cnt >= idle_cyc) begin
          s_nxt.st = S_AZ;
        end
      end
      S_PROG: begin
        // Programming blocks commands for its full time
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        if (s_r.cnt == 32'(PROG_CYC - 1)) begin
          s_nxt.nv[{s_r.pw_addr, 3'b000} +: 8] = s_r.pw_data;
          s_nxt.busy = 1'b0;
          s_nxt.st   = S_AZ;
        end
      end
      default: s_nxt.st = S_AZ;
    endcase

    if (i_req_valid && o_req_ready) begin
      case (i_req.cmd)
        CMD_READ: begin
          // Store read-out steps through the bytes in a ring
          s_nxt.rsp_v  = 1'b1;
          s_nxt.rsp_d  = nvb(s_r.nv, s_r.rd_ptr);
          s_nxt.rd_ptr = 4'(s_r.rd_ptr + 4'h1);
        end
        CMD_WRITE: begin
          s_nxt.busy    = 1'b1;
          s_nxt.pw_addr = i_req.addr;
          s_nxt.pw_data = i_req.data;
        end
        CMD_RAW: begin
          // addr[0] picks temperature or bridge
          s_nxt.rsp_v = 1'b1;
          s_nxt.rsp_d = i_req.addr[0] ? s_r.t_raw[13:6] : s_r.b_raw[13:6];
          if (i_req.addr[1]) begin
            s_nxt.rsp_d = i_req.addr[0] ? {2'b00, s_r.t_raw[5:0]}
                                        : {2'b00, s_r.b_raw[5:0]};
          end
        end
        default: s_nxt.rd_ptr = 4'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_r       <= '0;
      s_r.st    <= S_AZ;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic conv_phase;
  assign conv_phase = (s_r.st == S_AZ) || (s_r.st == S_TEMP)
                   || (s_r.st == S_BR);

  assign o_req_ready    = !s_r.busy && (s_r.st != S_PROG);
  assign o_rsp          = '{valid: s_r.rsp_v, data: s_r.rsp_d};
  assign o_conv_start   = conv_phase;
  assign o_conv_temp    = (s_r.st == S_TEMP);
  assign o_conv_az      = (s_r.st == S_AZ);
  // Switch follows conversions on at fastest rate
  assign o_bridge_sw_on = conv_phase || (rate == 2'h0);
  assign o_pga_gain     = cfg0[CFG_GAIN_LSB +: 2];
  assign o_input_swap   = cfg0[CFG_REV_BIT];
  assign o_adc_zero     = cfg0[CFG_ZERO_LSB +: 2];
  assign o_result       = '{bridge: s_r.br, temp: s_r.temp,
                            valid: s_r.valid};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sw_bridge;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_r.st == S_BR) |-> o_bridge_sw_on;
  endproperty
  a_sw_bridge: assert property (p_sw_bridge)
    else $error("bridge switch off during conversion");

  property p_az_then_temp;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_r.st == S_AZ && i_adc_done) |=> (s_r.st == S_TEMP);
  endproperty
  a_az_then_temp: assert property (p_az_then_temp)
    else $error("auto-zero not followed by temperature");

  property p_temp_then_br;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_r.st == S_TEMP && i_adc_done) |=> (s_r.st == S_BR);
  endproperty
  a_temp_then_br: assert property (p_temp_then_br)
    else $error("temperature not followed by bridge");

  property p_sat;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_r.st == S_CALC && s_r.step != 3'h0 && brq > 32'sd16383)
        |=> (s_r.br == ADC_MAX);
  endproperty
  a_sat: assert property (p_sat)
    else $error("bridge value not saturated");

  property p_temp8;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_r.st == S_CALC && s_r.step != 3'h0)
        |=> (s_r.temp == $past(tprod[15:8]));
  endproperty
  a_temp8: assert property (p_temp8)
    else $error("temperature byte wrong");

  sequence s_write_taken;
    i_req_valid && o_req_ready && i_req.cmd == CMD_WRITE;
  endsequence
  property p_prog_block;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_write_taken |=> !o_req_ready [*8];
  endproperty
  a_prog_block: assert property (p_prog_block)
    else $error("command taken during programming");

  property p_read_ptr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_req_valid && o_req_ready && i_req.cmd == CMD_READ)
        |=> (o_rsp.valid && s_r.rd_ptr == 4'($past(s_r.rd_ptr) + 4'h1));
  endproperty
  a_read_ptr: assert property (p_read_ptr)
    else $error("read did not advance one byte");

  property p_raw_rsp;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_req_valid && o_req_ready && i_req.cmd == CMD_RAW) |=> o_rsp.valid;
  endproperty
  a_raw_rsp: assert property (p_raw_rsp)
    else $error("raw value not returned");

endmodule

`default_nettype wire

// ===== verif/bridge_adc_model.sv
/*
  Behavioural converter and bridge for the correction core.
  Assumes the core shows its phase on conv_start, conv_az and conv_temp.
*/
`timescale 1ns/10ps
`default_nettype none

module bridge_adc_model #(
  parameter int DLY = 5
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_conv_start,
  input  wire logic        i_conv_temp,
  input  wire logic        i_conv_az,
  input  wire logic        i_bridge_sw_on,
  input  wire logic [13:0] i_az_val,
  input  wire logic [13:0] i_temp_val,
  input  wire logic [13:0] i_br_val,
  output var  logic [13:0] o_adc_data,
  output var  logic        o_adc_done
);
  logic [1:0] ph_done;
  logic       fired;
  int         cnt;

  initial begin
    o_adc_data = 14'h0000;
    o_adc_done = 1'b0;
    fired      = 1'b0;
    cnt        = 0;
  end

  // One 14-bit result per phase; the data lines scramble between strobes
  always @(negedge i_clk) begin
    o_adc_done <= 1'b0;
    o_adc_data <= ~o_adc_data;
    if (!i_rst_n || !i_conv_start) begin
      cnt   <= 0;
      fired <= 1'b0;
    end else if (fired && ph_done != {i_conv_az, i_conv_temp}) begin
      cnt   <= 0;
      fired <= 1'b0;
    end else if (!fired) begin
      if (cnt == DLY) begin
        o_adc_done <= 1'b1;
        fired      <= 1'b1;
        ph_done    <= {i_conv_az, i_conv_temp};
        // An unpowered bridge reads as zero
        o_adc_data <= i_conv_az ? i_az_val : i_conv_temp ? i_temp_val :
                      i_bridge_sw_on ? i_br_val : 14'h0000;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_bridge_sensor_correction_dsp.sv
/*
  Self-checking bench for the correction core: command port, store,
  configuration outputs and bridge switch timing.
  Assumes shortened conversion idle and programming counts.
*/
`timescale 1ns/10ps
`default_nettype none

module test_bridge_sensor_correction_dsp;
  import bridge_dsp_pkg::*;

  localparam int CC = 10;
  localparam int PC = 20;

  logic        i_clk;
  logic        i_rst_n;
  host_req_t   i_req;
  logic        i_req_valid;
  logic        o_req_ready;
  host_rsp_t   o_rsp;
  logic [13:0] i_adc_data;
  logic        i_adc_done;
  logic        o_conv_start;
  logic        o_conv_temp;
  logic        o_conv_az;
  logic        o_bridge_sw_on;
  logic [1:0]  o_pga_gain;
  logic        o_input_swap;
  logic [1:0]  o_adc_zero;
  result_t     o_result;
  logic [7:0]  exp_nv [16];
  int          n_fail;
  int          n_tests;

  bridge_sensor_correction_dsp #(.CONV_CYC(CC), .PROG_CYC(PC))
    u_bridge_sensor_correction_dsp (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .o_rsp(o_rsp),
    .i_adc_data(i_adc_data), .i_adc_done(i_adc_done),
    .o_conv_start(o_conv_start), .o_conv_temp(o_conv_temp),
    .o_conv_az(o_conv_az), .o_bridge_sw_on(o_bridge_sw_on),
    .o_pga_gain(o_pga_gain), .o_input_swap(o_input_swap),
    .o_adc_zero(o_adc_zero), .o_result(o_result));

  bridge_adc_model #(.DLY(5)) u_bridge_adc_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv_start(o_conv_start),
    .i_conv_temp(o_conv_temp), .i_conv_az(o_conv_az),
    .i_bridge_sw_on(o_bridge_sw_on), .i_az_val(14'h0010),
    .i_temp_val(14'h2ABC), .i_br_val(14'h1234),
    .o_adc_data(i_adc_data), .o_adc_done(i_adc_done));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Held through the rising edge after ready is seen high, dropped at the next falling edge
  task automatic send(input cmd_t c, input logic [3:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    i_req       = '{cmd: c, addr: a, data: d};
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    check("ready wait", 16'(n < 3000), 16'h0001);
    @(posedge i_clk);
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask

  // Store write; checks that ready drops, and the next send waits out programming
  task automatic nv_write(input logic [3:0] a, input logic [7:0] d);
    send(CMD_WRITE, a, d);
    exp_nv[a] = d;
    check("busy after write", 16'(o_req_ready), 16'h0000);
  endtask

  task automatic query(input cmd_t c, input logic [3:0] a,
                       input logic [7:0] exp, input string nm);
    send(c, a, 8'h00);
    check({nm, " valid"}, 16'(o_rsp.valid), 16'h0001);
    check(nm, 16'(o_rsp.data), 16'(exp));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int nt;
    nt = 0;
    check("ready", 16'(o_req_ready), 16'h0001);
    check("rsp valid", 16'(o_rsp.valid), 16'h0000);
    check("result", 16'(o_result.valid), 16'h0000);
    check("az phase", 16'({o_conv_az, o_conv_start}), 16'h0003);
    repeat (60) begin
      @(negedge i_clk);
      nt += int'(o_conv_temp === 1'b1);
      check("switch rate 0", 16'(o_bridge_sw_on), 16'h0001);
    end
    check("temp phase", 16'(nt > 0), 16'h0001);
    check("result after run", 16'(o_result.valid), 16'h0001);
    $display("t_reset done");
  endtask

  task automatic t_raw();
    // Bridge raw is the bridge reading less auto-zero: 1234 - 0010
    query(CMD_RAW, 4'h0, 8'h48, "raw bridge hi");
    query(CMD_RAW, 4'h2, 8'h24, "raw bridge lo");
    query(CMD_RAW, 4'h1, 8'hAA, "raw temp hi");
    query(CMD_RAW, 4'h3, 8'h3C, "raw temp lo");
    $display("t_raw done");
  endtask

  task automatic t_cfg();
    logic [7:0] v;
    for (int g = 0; g < 4; g++) begin
      v = 8'({2'(3 - g), 1'(g), 2'(g)});
      nv_write(NV_CFG0, {1'b0, v[6:0]});
      send(CMD_NONE, 4'h0, 8'h00);
      check("gain", 16'(o_pga_gain), 16'(g));
      check("swap", 16'(o_input_swap), 16'(g & 1));
      check("zero", 16'(o_adc_zero), 16'(3 - g));
    end
    $display("t_cfg done");
  endtask

  task automatic t_store();
    // Offsets stay zero so no negative bridge offset is needed
    nv_write(NV_CUST0, 8'hA5);
    nv_write(NV_CUST1, 8'h5A);
    nv_write(NV_CUST2, 8'hC3);
    nv_write(NV_TCO, 8'h81);
    send(CMD_NONE, 4'h0, 8'h00);
    for (int i = 0; i < 17; i++)
      query(CMD_READ, 4'h0, exp_nv[i % 16], "store byte");
    $display("t_store done");
  endtask

  // Picks the second-order target and bridge gain, then waits out
  // programming and one full measurement before looking at the result
  task automatic calc_case(input logic [7:0] tgt, input logic [7:0] g_hi,
                           input logic [13:0] exp_br, input string nm);
    nv_write(NV_CFG1, tgt);
    nv_write(NV_GAIN_B_HI, g_hi);
    send(CMD_NONE, 4'h0, 8'h00);
    repeat (60) @(negedge i_clk);
    check(nm, 16'(o_result.bridge), 16'(exp_br));
  endtask

  task automatic t_calc();
    // Gain Q12, Tco in sixteenths, Tcg and SECOND_ORDER_COEFFICIENT on gain in 1/64 of Q12.
    // Raw 4644, offset 548, dT 16, Tco 16: offset term 4112.
    nv_write(NV_OFS_B_LO, 8'h24);
    nv_write(NV_OFS_B_HI, 8'h02);
    nv_write(NV_TCO, 8'h10);
    nv_write(NV_SOT, 8'h01);
    nv_write(NV_TSETL_LO, 8'h9F);
    nv_write(NV_TSETL_HI, 8'h0A);
    nv_write(NV_GAIN_T, 8'h10);
    nv_write(NV_OFS_T, 8'h01);
    // 4112 x 1.25
    calc_case(8'h00, 8'h10, 14'h1414, "bridge 2nd order");
    // Sixteen x (2736) = 0xAB00, upper byte out
    check("temperature", 16'(o_result.temp), 16'h00AB);
    // 4096 + 16 x (16 + 16) / 16
    calc_case(8'h01, 8'h10, 14'h1020, "offset 2nd order");
    // Gain 4100 / 4096 on 4112
    calc_case(8'h02, 8'h10, 14'h1014, "gain 2nd order");
    // Gain 4.0 drives the result past full scale
    calc_case(8'h00, 8'h40, 14'h3FFF, "saturated");
    $display("t_calc done");
  endtask

  task automatic t_rate();
    int low;
    int sw;
    int n;
    low = 0;
    sw  = 0;
    n   = 0;
    nv_write(NV_CFG0, 8'h60);
    send(CMD_NONE, 4'h0, 8'h00);
    while (o_conv_start !== 1'b0 && n < 500) begin
      @(negedge i_clk);
      n++;
    end
    while (o_conv_start === 1'b0 && low < 3000) begin
      low++;
      sw += int'(o_bridge_sw_on === 1'b1);
      @(negedge i_clk);
    end
    check("idle span", 16'(low >= 99 * CC && low <= 99 * CC + 4),
          16'h0001);
    check("switch off idle", 16'(sw), 16'h0000);
    check("switch on conv", 16'(o_bridge_sw_on), 16'h0001);
    $display("t_rate done");
  endtask

  initial begin
    #400_000;
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail      = 0;
    n_tests     = 0;
    i_rst_n     = 1'b0;
    i_req       = '{cmd: CMD_NONE, addr: 4'h0, data: 8'h00};
    i_req_valid = 1'b0;
    for (int i = 0; i < 16; i++)
      exp_nv[i] = 8'h00;
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_raw();
    t_cfg();
    t_store();
    t_calc();
    t_rate();
    give_verdict();
  end
endmodule
`default_nettype wire
